/* File: src/ssm_pkg.sv */
// ssm_pkg: register map, field positions, reset values and carrier types
// for the safe-stop source monitor.
// assumes a plain 8-bit address register port with 32-bit data.
package ssm_pkg;

  localparam int          SSM_ADDR_W = 8;
  localparam int          SSM_DATA_W = 32;

  // register byte offsets
  localparam logic [7:0]  SSM_OFS_ALARM      = 8'h00;
  localparam logic [7:0]  SSM_OFS_ALARM_TWO  = 8'h04;
  localparam logic [7:0]  SSM_OFS_WARN       = 8'h08;
  localparam logic [7:0]  SSM_OFS_WARN_TWO   = 8'h0C;
  localparam logic [7:0]  SSM_OFS_CONFIG     = 8'h10;
  localparam logic [7:0]  SSM_OFS_CONTROL    = 8'h14;
  localparam logic [7:0]  SSM_OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0]  SSM_OFS_IRQ_MASK   = 8'h1C;
  localparam logic [7:0]  SSM_OFS_STATE      = 8'h20;

  // status word bit positions
  localparam int          SSM_BIT_STOP_EVENT = 30;
  localparam int          SSM_BIT_CARD_EVENT = 30;
  localparam int          SSM_BIT_DANGER     = 31;

  // config and control fields
  localparam int          SSM_RESP_W         = 4;
  localparam int          SSM_BIT_RESET_CMD  = 0;

  // stop-response settings
  localparam logic [3:0]  SSM_RESP_NONE      = 4'h0;
  localparam logic [3:0]  SSM_RESP_ALARM     = 4'h1;
  localparam logic [3:0]  SSM_RESP_ALARM_ALT = 4'h2;
  localparam logic [3:0]  SSM_RESP_WARN      = 4'h3;
  localparam logic [3:0]  SSM_RESP_CARD_A    = 4'h4;
  localparam logic [3:0]  SSM_RESP_CARD_W    = 4'h5;
  localparam logic [3:0]  SSM_RESP_BOTH_A    = 4'h6;
  localparam logic [3:0]  SSM_RESP_BOTH_W    = 4'h7;
  localparam logic [3:0]  SSM_RESP_BOTH_AW   = 4'h8;
  localparam logic [3:0]  SSM_RESP_BOTH_WA   = 4'h9;
  localparam logic [3:0]  SSM_RESP_RESET     = SSM_RESP_ALARM;

  // interrupt event bits
  localparam int          SSM_IRQ_W          = 5;
  localparam int          SSM_IRQ_STOP_WARN  = 0;
  localparam int          SSM_IRQ_CARD_WARN  = 1;
  localparam int          SSM_IRQ_STOP_ALARM = 2;
  localparam int          SSM_IRQ_CARD_ALARM = 3;
  localparam int          SSM_IRQ_DANGER     = 4;
  localparam logic [4:0]  SSM_IRQ_MASK_RESET = 5'h00;

  typedef enum logic [3:0] {
    SSM_RUN   = 4'h1,
    SSM_WARN  = 4'h2,
    SSM_ALARM = 4'h4,
    SSM_LOCK  = 4'h8
  } ssm_state_t;

  // one sampled pair of stop inputs, both active high
  typedef struct packed {
    logic stop_active;
    logic card_active;
  } ssm_inputs_t;

  typedef struct packed {
    logic [SSM_ADDR_W-1:0] addr;
    logic [SSM_DATA_W-1:0] wdata;
    logic                  wr;
    logic                  rd;
  } ssm_bus_req_t;

endpackage : ssm_pkg

/* File: src/ssm_safe_stop_monitor.sv */
// ssm_safe_stop_monitor: classifies safe-stop events by source, latches
// alarms, reports warnings, raises the dangerous-failure trip lock.
// assumes one clock, a plain register port and pulse reset inputs.
//
// The plain strobed port and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none

module ssm_safe_stop_monitor
  import ssm_pkg::*;
(
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       safe_stop_n,
  input  wire logic                       card_stop_indication,
  input  wire logic                       card_in_slot,
  input  wire logic                       reset_panel,
  input  wire logic                       reset_digital,
  input  wire logic                       reset_fieldbus,
  input  wire ssm_pkg::ssm_bus_req_t      bus_req,
  output logic [ssm_pkg::SSM_DATA_W-1:0]  bus_rdata,
  output logic                            coast,
  output logic                            irq
);
  import ssm_pkg::*;

  logic [1:0]          sync_meta;
  ssm_inputs_t         smp;
  logic [3:0]          response;
  logic                stop_alarm;
  logic                card_alarm;
  logic                danger;
  logic                stop_warn_q;
  logic                card_warn_q;
  logic [SSM_IRQ_W-1:0] irq_status;
  logic [SSM_IRQ_W-1:0] irq_mask;
  ssm_state_t          state;
  ssm_state_t          next_state;
  logic [SSM_DATA_W-1:0] next_rdata;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync_meta <= 2'h0;
      smp       <= '0;
    end else begin
      sync_meta <= {~safe_stop_n, card_stop_indication};
      smp       <= sync_meta;
    end
  end

  // register port decode
  wire wr_config  = bus_req.wr && (bus_req.addr == SSM_OFS_CONFIG);
  wire wr_control = bus_req.wr && (bus_req.addr == SSM_OFS_CONTROL);
  wire wr_irq_st  = bus_req.wr && (bus_req.addr == SSM_OFS_IRQ_STATUS);
  wire wr_irq_msk = bus_req.wr && (bus_req.addr == SSM_OFS_IRQ_MASK);
  wire [3:0] wr_resp = bus_req.wdata[SSM_RESP_W-1:0];

  // response decode
  wire card_mode  = (response >= SSM_RESP_CARD_A)
                 && (response <= SSM_RESP_BOTH_WA);
  wire card_only  = (response == SSM_RESP_CARD_A)
                 || (response == SSM_RESP_CARD_W);
  wire relay_mode = card_mode && !card_only;
  wire plain_mode = (response == SSM_RESP_ALARM)
                 || (response == SSM_RESP_ALARM_ALT)
                 || (response == SSM_RESP_WARN);

  // card alarm in 4, 6 and 8
  wire card_alarm_mode = (response == SSM_RESP_CARD_A)
                      || (response == SSM_RESP_BOTH_A)
                      || (response == SSM_RESP_BOTH_AW);
  // relay alarm in 6 and 9, warning in 7 and 8
  wire relay_alarm_mode = (response == SSM_RESP_BOTH_A)
                       || (response == SSM_RESP_BOTH_WA);
  wire stop_alarm_mode  = relay_alarm_mode
                       || (response == SSM_RESP_ALARM)
                       || (response == SSM_RESP_ALARM_ALT);

  // indication only counts in card settings
  wire card_used = card_mode && smp.card_active;

  wire danger_orphan = card_used && !smp.stop_active;
  wire danger_stray  = card_only && smp.stop_active && !card_used;
  wire danger_event  = danger_orphan || danger_stray;

  // card stop seen as both inputs active
  wire card_stop  = card_mode && smp.stop_active && card_used;
  wire relay_stop = smp.stop_active && !card_used
                 && (relay_mode || plain_mode);

  wire card_alarm_event = card_stop && card_alarm_mode;
  wire card_warn_cond   = card_stop && !card_alarm_mode;
  wire stop_alarm_event = relay_stop && stop_alarm_mode;
  wire stop_warn_cond   = relay_stop && !stop_alarm_mode;

  wire manual_reset = reset_panel || reset_digital || reset_fieldbus
                   || (wr_control && bus_req.wdata[SSM_BIT_RESET_CMD]);

  wire stop_clear_ok = !smp.stop_active;
  // card alarm also needs indication gone
  wire card_clear_ok = !smp.stop_active && !smp.card_active;
  wire reset_ok      = manual_reset
                    && (!stop_alarm || stop_clear_ok)
                    && (!card_alarm || card_clear_ok);

  wire resp_legal = (wr_resp <= SSM_RESP_WARN)
                 || (card_in_slot && (wr_resp <= SSM_RESP_BOTH_WA));

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      response <= SSM_RESP_RESET;
    end else if (wr_config && resp_legal) begin
      response <= wr_resp;
    end
  end

  // alarm latches: a new event beats a reset in the same cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stop_alarm <= 1'b0;
      card_alarm <= 1'b0;
    end else begin
      // stop alarm held until manual reset
      stop_alarm <= stop_alarm_event || (stop_alarm && !reset_ok);
      // card alarm held until manual reset
      card_alarm <= card_alarm_event || (card_alarm && !reset_ok);
    end
  end

  // trip lock: only the system reset releases it
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      danger <= 1'b0;
    end else if (danger_event) begin
      danger <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      stop_warn_q <= 1'b0;
      card_warn_q <= 1'b0;
    end else begin
      stop_warn_q <= stop_warn_cond;
      card_warn_q <= card_warn_cond;
    end
  end

  wire alarm_any = stop_alarm || card_alarm
                || stop_alarm_event || card_alarm_event;
  wire warn_any  = stop_warn_cond || card_warn_cond;

  // alarms leave by manual reset, or for the lock on a danger event
  always_comb begin
    next_state = state;
    unique case (state)
      SSM_RUN, SSM_WARN: begin
        if (danger_event) begin
          next_state = SSM_LOCK;
        end else if (alarm_any) begin
          next_state = SSM_ALARM;
        end else if (warn_any) begin
          next_state = SSM_WARN;
        end else begin
          next_state = SSM_RUN;
        end
      end
      SSM_ALARM: begin
        if (danger_event) begin
          next_state = SSM_LOCK;
        end else if (reset_ok && !stop_alarm_event && !card_alarm_event) begin
          next_state = warn_any ? SSM_WARN : SSM_RUN;
        end
      end
      SSM_LOCK: begin
        next_state = SSM_LOCK;
      end
      default: begin
        next_state = SSM_LOCK;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= SSM_RUN;
    end else begin
      state <= next_state;
    end
  end

  // coast while any stop cause remains
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      coast <= 1'b0;
    end else begin
      coast <= (next_state != SSM_RUN) || smp.stop_active;
    end
  end

  // card warning sets its bit once, on the first cycle both inputs stand
  wire [SSM_IRQ_W-1:0] irq_set;
  assign irq_set[SSM_IRQ_STOP_WARN]  = stop_warn_cond && !stop_warn_q;
  assign irq_set[SSM_IRQ_CARD_WARN]  = card_warn_cond && !card_warn_q;
  assign irq_set[SSM_IRQ_STOP_ALARM] = stop_alarm_event && !stop_alarm;
  assign irq_set[SSM_IRQ_CARD_ALARM] = card_alarm_event && !card_alarm;
  assign irq_set[SSM_IRQ_DANGER]     = danger_event && !danger;

  // sticky status, write one to clear, set wins
  genvar gi;
  generate
    for (gi = 0; gi < SSM_IRQ_W; gi++) begin : g_irq
      wire clr = wr_irq_st && bus_req.wdata[gi];
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          irq_status[gi] <= 1'b0;
        end else begin
          irq_status[gi] <= irq_set[gi] || (irq_status[gi] && !clr);
        end
      end
    end
  endgenerate

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      irq_mask <= SSM_IRQ_MASK_RESET;
    end else if (wr_irq_msk) begin
      irq_mask <= bus_req.wdata[SSM_IRQ_W-1:0];
    end
  end

  assign irq = |(irq_status & irq_mask);

  wire [SSM_DATA_W-1:0] alarm_word;
  wire [SSM_DATA_W-1:0] alarm_word_two;
  wire [SSM_DATA_W-1:0] warn_word;
  wire [SSM_DATA_W-1:0] warn_word_two;
  assign alarm_word     = {{(SSM_DATA_W-1){1'b0}}, stop_alarm}
                          << SSM_BIT_STOP_EVENT;
  assign alarm_word_two = ({{(SSM_DATA_W-1){1'b0}}, card_alarm}
                          << SSM_BIT_CARD_EVENT)
                        | ({{(SSM_DATA_W-1){1'b0}}, danger}
                          << SSM_BIT_DANGER);
  assign warn_word      = {{(SSM_DATA_W-1){1'b0}}, stop_warn_q}
                          << SSM_BIT_STOP_EVENT;
  assign warn_word_two  = {{(SSM_DATA_W-1){1'b0}}, card_warn_q}
                          << SSM_BIT_CARD_EVENT;

  // read mux; unmapped offsets read zero
  always_comb begin
    next_rdata = '0;
    unique case (bus_req.addr)
      SSM_OFS_ALARM:      next_rdata = alarm_word;
      SSM_OFS_ALARM_TWO:  next_rdata = alarm_word_two;
      SSM_OFS_WARN:       next_rdata = warn_word;
      SSM_OFS_WARN_TWO:   next_rdata = warn_word_two;
      SSM_OFS_CONFIG:     next_rdata = {28'h0000000, response};
      SSM_OFS_IRQ_STATUS: next_rdata = {27'h0000000, irq_status};
      SSM_OFS_IRQ_MASK:   next_rdata = {27'h0000000, irq_mask};
      SSM_OFS_STATE:      next_rdata = {26'h0000000, smp, state};
      default:            next_rdata = '0;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bus_rdata <= '0;
    end else if (bus_req.rd) begin
      bus_rdata <= next_rdata;
    end else begin
      bus_rdata <= '0;
    end
  end

endmodule : ssm_safe_stop_monitor

`default_nettype wire

/* File: test/ssm_card_relay_model.sv */
// ssm_card_relay_model: thermistor card and emergency-stop relay
// assumes commands arrive by non-blocking assignment at the clock edge
`timescale 1ns/1ns
`default_nettype none
module ssm_card_relay_model (
  input  wire logic clock,
  input  wire logic card_trip,
  input  wire logic relay_trip,
  input  wire logic fault,
  output var logic  safe_stop_n,
  output var logic  card_stop_indication
);
  initial begin
    safe_stop_n = 1'b1;
    card_stop_indication = 1'b0;
  end
  // card drives both lines, relay the stop line only
  // fault raises the indication alone, only when commanded
  always @(posedge clock) begin
    safe_stop_n <= !(card_trip || relay_trip);
    card_stop_indication <= card_trip || fault;
  end
endmodule : ssm_card_relay_model
`default_nettype wire

/* File: test/ssm_safe_stop_monitor_chk.sv */
// ssm_chk: port assertions for the safe-stop monitor
// assumes an input change reaches coast three edges later
`timescale 1ns/1ns
`default_nettype none
module ssm_chk
  import ssm_pkg::*;
(
  input wire logic                          clock,
  input wire logic                          rst_n,
  input wire logic                          safe_stop_n,
  input wire logic                          card_stop_indication,
  input wire logic                          card_in_slot,
  input wire logic                          reset_panel,
  input wire logic                          reset_digital,
  input wire logic                          reset_fieldbus,
  input wire ssm_pkg::ssm_bus_req_t         bus_req,
  input wire logic [ssm_pkg::SSM_DATA_W-1:0] bus_rdata,
  input wire logic                          coast,
  input wire logic                          irq
);
  import ssm_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  logic [2:0] up;
  logic [3:0] cfg;
  logic [4:0] msk;
  logic [4:0] rq;
  logic       dang;
  wire logic  wcfg = bus_req.wr && bus_req.addr == SSM_OFS_CONFIG
    && bus_req.wdata[3:0] < 4'hA
    && (bus_req.wdata[3:0] < 4'h4 || card_in_slot);
  wire logic  wmsk = bus_req.wr && bus_req.addr == SSM_OFS_IRQ_MASK;
  // any reset request, pins or control write, taken at this edge
  wire logic  rreq = reset_panel || reset_digital || reset_fieldbus
    || (bus_req.wr && bus_req.addr == SSM_OFS_CONTROL && bus_req.wdata[0]);
  // shadows of mode and mask; up hides pre-reset history
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      up <= 3'h0;
      cfg <= SSM_RESP_RESET;
      msk <= 5'h00;
      rq <= 5'h00;
      dang <= 1'b0;
    end else begin
      up <= (up == 3'h4) ? up : up + 3'h1;
      rq <= {rq[3:0], rreq};
      if (wcfg) cfg <= bus_req.wdata[3:0];
      if (wmsk) msk <= bus_req.wdata[4:0];
      // unexpected pair seen on one sample
      if (up == 3'h4 && cfg >= 4'h4 && ($past(card_stop_indication, 2)
          && $past(safe_stop_n, 2) || cfg <= 4'h5
          && !$past(card_stop_indication, 2) && !$past(safe_stop_n, 2)))
        dang <= 1'b1;
    end
  end
  rdata_idle_a: assert property (
    !$past(bus_req.rd) |-> bus_rdata == '0)
    else $error("read data outside its slot");
  stop_coast_a: assert property (
    up == 3'h4 && !$past(safe_stop_n, 3) |-> coast)
    else $error("active stop without coast");
  danger_lock_a: assert property (dang |-> coast)
    else $error("danger trip not holding coast");
  warn_restart_a: assert property (
    cfg == 4'h3 && up == 3'h4 && $past(safe_stop_n, 3) |-> !coast)
    else $error("stop warning did not restart");
  both_warn_a: assert property (
    (cfg == 4'h5 || cfg == 4'h7) && !dang && up == 3'h4
    && $past(safe_stop_n, 3) && !$past(card_stop_indication, 3) |-> !coast)
    else $error("warning mode did not restart");
  alarm_hold_a: assert property (
    cfg == 4'h1 && coast && rq == 5'h00 && !rreq |=> coast)
    else $error("stop alarm left without reset");
  card_hold_a: assert property (
    (cfg == 4'h4 || cfg == 4'h6) && coast && $past(card_stop_indication)
    && $past(card_stop_indication, 2) |=> coast)
    else $error("card alarm left while card active");
  irq_mask_a: assert property (msk == 5'h00 |-> !irq)
    else $error("interrupt with all events masked");
endmodule : ssm_chk
bind ssm_safe_stop_monitor ssm_chk u_chk (.clock(clock), .rst_n(rst_n),
  .safe_stop_n(safe_stop_n), .card_stop_indication(card_stop_indication),
  .card_in_slot(card_in_slot), .reset_panel(reset_panel),
  .reset_digital(reset_digital), .reset_fieldbus(reset_fieldbus),
  .bus_req(bus_req), .bus_rdata(bus_rdata), .coast(coast), .irq(irq));
`default_nettype wire

/* File: test/ssm_safe_stop_monitor_tb_top.sv */
// ssm_safe_stop_monitor_tb_top: every setting against card, relay
// and faulty-card stops; assumes the partner model and bound checker
`timescale 1ns/1ns
`default_nettype none
module ssm_safe_stop_monitor_tb_top;
  import ssm_pkg::*;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic card_trip = 1'b0;
  logic relay_trip = 1'b0;
  logic fault = 1'b0;
  logic slot = 1'b1;
  logic [2:0] rs = 3'h0;
  ssm_bus_req_t req = '0;
  wire logic stop_n;
  wire logic card_ind;
  logic [31:0] rdata;
  logic coast;
  logic irq;
  int miscompares = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2 clock = ~clock;
  // the indication line serves the card alone
  ssm_card_relay_model partner (.clock(clock), .card_trip(card_trip),
    .relay_trip(relay_trip), .fault(fault), .safe_stop_n(stop_n),
    .card_stop_indication(card_ind));
  ssm_safe_stop_monitor uut (.clock(clock), .rst_n(rst_n),
    .safe_stop_n(stop_n), .card_stop_indication(card_ind),
    .card_in_slot(slot), .reset_panel(rs[0]), .reset_digital(rs[1]),
    .reset_fieldbus(rs[2]), .bus_req(req), .bus_rdata(rdata),
    .coast(coast), .irq(irq));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: %h, expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrap_up;
    $display("compares %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clock);
    req <= '0;
    @(posedge clock);
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clock);
    req <= '0;
    #1 chk(rdata, e);
    @(posedge clock);
  endtask : rd
  task automatic see(input logic c, input logic i);
    #1 chk({31'h0, coast}, {31'h0, c});
    chk({31'h0, irq}, {31'h0, i});
    @(posedge clock);
  endtask : see
  // manual reset from a random source: a pin or the control word
  task automatic manual;
    if ($urandom % 4 == 0) begin
      wr(SSM_OFS_CONTROL, 32'h1);
    end else begin
      rs <= 3'h1 << ($urandom % 3);
      @(posedge clock);
      rs <= 3'h0;
    end
  endtask : manual
  task automatic run(input logic [3:0] s, input logic [1:0] m);
    logic ce, se, ca, cw, sa, sw, d;
    ce = m == 2'd0 && s >= 4'h4;
    se = s != 4'h0 && (m == 2'd0 && s < 4'h4
         || m == 2'd1 && !(s inside {4'h4, 4'h5}));
    // alarm or warning per stop source
    ca = ce && s inside {4'h4, 4'h6, 4'h8};
    cw = ce && !ca;
    sa = se && s inside {4'h1, 4'h2, 4'h6, 4'h9};
    sw = se && !sa;
    d = s >= 4'h4 && (m == 2'd2 || m == 2'd1 && s < 4'h6);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    wr(SSM_OFS_CONFIG, {28'h0, s});
    wr(SSM_OFS_IRQ_MASK, 32'h1F);
    rd(SSM_OFS_CONFIG, {28'h0, s});
    card_trip <= m == 2'd0;
    relay_trip <= m == 2'd1;
    fault <= m == 2'd2;
    repeat (4 + $urandom % 6) @(posedge clock);
    manual();
    rd(SSM_OFS_ALARM_TWO, {d, ca, 30'h0});
    rd(SSM_OFS_WARN_TWO, {1'b0, cw, 30'h0});
    if (!d) rd(SSM_OFS_ALARM, {1'b0, sa, 30'h0});
    if (!d) rd(SSM_OFS_WARN, {1'b0, sw, 30'h0});
    see(m != 2'd2 || d, sa | sw | ca | cw | d);
    wr(SSM_OFS_IRQ_STATUS, 32'h1F);
    see(m != 2'd2 || d, 1'b0);
    card_trip <= 1'b0;
    relay_trip <= 1'b0;
    fault <= 1'b0;
    repeat (8) @(posedge clock);
    see(sa || ca || d, 1'b0);
    manual();
    repeat (6) @(posedge clock);
    see(d, 1'b0);
  endtask : run
  // the whole run needs about 1350 cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(32'hB13C4AA0));
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(SSM_OFS_CONFIG, 32'h1);
    rd(SSM_OFS_IRQ_MASK, 32'h0);
    rd(SSM_OFS_STATE, 32'h1);
    rd(8'h40, 32'h0);
    rd(SSM_OFS_CONTROL, 32'h0);
    wr(SSM_OFS_ALARM_TWO, $urandom);
    rd(SSM_OFS_ALARM_TWO, 32'h0);
    slot <= 1'b0;
    wr(SSM_OFS_CONFIG, 32'h4);
    slot <= 1'b1;
    wr(SSM_OFS_CONFIG, 32'hA);
    rd(SSM_OFS_CONFIG, 32'h1);
    for (int s = 0; s < 10; s++) begin
      for (int m = 0; m < 3; m++) begin
        run(s[3:0], m[1:0]);
      end
    end
    wrap_up();
  end
endmodule : ssm_safe_stop_monitor_tb_top
`default_nettype wire
